// >>> hdl/eimap_cfg.svh
// constants of the external-interrupt front end and vector map
// assumes a single 100 MHz cpu clock and an axi4-lite register slave
//
// Functional notes
// RULE_01: fixed priority reset down to serial port; two-byte vectors descending from top.
// RULE_02: auto-reload overflow has own vector; ends active-halt only.
// RULE_03: lite periodic one has lowest timer vector; ends active-halt.
// RULE_04: lite capture has own vector; never ends active-halt.
// RULE_05: lite periodic two vectored below external lines; no halt wake.
// RULE_06: auto wake source ends auto-wake halt only, not ordinary halt.
// RULE_07: in halt only auto wake and halt-capable sources may wake.
// RULE_08: sensitivity register: line3 7:6, line2 5:4, line1 3:2, line0 1:0.
// RULE_09: line zero fixed to port a pin 0, line one to pin 7.
// RULE_10: sense 00 fall+low, 01 rise, 10 fall, 11 both edges.
// RULE_11: sensitivity writes taken only while core interrupt mask is set.
// RULE_12: line three pin: 00 port b pin0, 01 pin1, 10 pin2.
// RULE_13: line two pin: 00 pin3, 01 pin4, 10 pin5, 11 pin6.
// RULE_14: pin select register resets to 0Ch.
// RULE_15: line two on port b pin four gives nothing in halt.
// RULE_16: on entry push condition codes, load priority bits with routine level.
// RULE_17: vector fetch clears that external line's pending latch.
// RULE_18: any sensitivity change discards all pending external requests.
// RULE_19: pin counts only when input direction and option bit set.
// RULE_20: pins synchronised; edges by sample compare; fall+low holds while low.
`ifndef EIMAP_CFG_SVH
`define EIMAP_CFG_SVH

`define SENS_OFS 8'h00
`define SEL_OFS 8'h04
`define STAT_OFS 8'h08
`define SENS_RST 8'h00
`define SEL_RST 8'h0C
`define L3_FIELD 7:6
`define L2_FIELD 5:4
`define L1_FIELD 3:2
`define L0_FIELD 1:0
`define SENSE_FALL_LOW 2'h0
`define SENSE_RISE 2'h1
`define SENSE_FALL 2'h2
`define SENSE_BOTH 2'h3
`define LINE0_PIN 3'h0
`define LINE1_PIN 3'h7
`define LINE2_BASE 3'h3
`define LINE3_NONE 2'h3
`define LINE2_PB4 2'h1
`define LEVEL_MASKED 2'h3
`define VEC_TOP 16'hFFFE
`define SLOT_RESET 4'h0
`define SLOT_EXT0 4'h3
`define WAKE_HALT 16'h4079
`define WAKE_AWU_HALT 16'h407D
`define WAKE_ACT_HALT 16'h2801
`define WAKE_RUN 16'hFFFF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> hdl/eimap_pkg.sv
// types shared by the interrupt map and its bench
// assumes eimap_cfg.svh supplies every constant
package eimap_pkg;

	typedef enum logic [1:0] {
		PM_RUN,
		PM_HALT,
		PM_ACTIVE_HALT,
		PM_AWU_HALT
	} power_mode_e;

	typedef struct packed {
		logic trap;
		logic auto_wake_source;
		logic lite_two;
		logic supply_warning_source;
		logic at_cmp;
		logic at_ovf;
		logic lite_cap;
		logic lite_one;
		logic spi;
	} periph_req_s;

	typedef struct packed {
		logic valid;
		logic [3:0] slot;
		logic [15:0] vector;
	} irq_req_s;

endpackage : eimap_pkg

// >>> hdl/ext_interrupt_and_vector_map.sv
// external interrupt front end, priority encoder and vector map
// assumes port pins are asynchronous; all other inputs are on i_mclk
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "eimap_cfg.svh"

module ext_interrupt_and_vector_map #(
	parameter int ADDR_W = 8
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	output logic [1:0] o_s_axi_bresp,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	input wire logic [ADDR_W-1:0] i_s_axi_araddr,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	input wire logic [7:0] i_port_a,
	input wire logic [7:0] i_port_b,
	input wire logic [7:0] i_port_a_dir,
	input wire logic [7:0] i_port_a_opt,
	input wire logic [7:0] i_port_b_dir,
	input wire logic [7:0] i_port_b_opt,
	input wire eimap_pkg::periph_req_s i_periph_req,
	input wire eimap_pkg::power_mode_e i_power_mode,
	input wire logic [1:0] i_cc_level,
	input wire logic [1:0] i_routine_level,
	input wire logic i_vec_fetch,
	output eimap_pkg::irq_req_s o_irq,
	output logic o_wake,
	output logic o_cc_push,
	output logic [1:0] o_cc_level
);

	// ************************************************************
	// decode helpers
	// ************************************************************

	// one edge event for a line under its sense field; the fall+low level is added by line_hold
	function automatic logic sense_event(input logic [1:0] mode,
			input logic prev, input logic cur);
		logic rise;
		logic fall;
		rise = ~prev & cur;
		fall = prev & ~cur;
		unique case (mode)
			`SENSE_FALL_LOW: sense_event = fall; // RULE_10
			`SENSE_RISE: sense_event = rise; // RULE_10
			`SENSE_FALL: sense_event = fall; // RULE_10
			`SENSE_BOTH: sense_event = rise | fall; // RULE_10
		endcase
	endfunction : sense_event

	// lowest set index wins: slot 0 is highest priority
	function automatic logic [3:0] first_set(input logic [15:0] req);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (req[i]) begin
				idx = 4'(i);
			end
		end
		first_set = idx;
	endfunction : first_set

	// ************************************************************
	// pin synchronisers
	// ************************************************************

	logic [15:0] pin_raw;
	logic [15:0] pin_s1_q;
	logic [15:0] pin_s2_q;
	logic [15:0] pin_s3_q;
	logic [15:0] pin_stable_q;

	assign pin_raw = {i_port_b, i_port_a};

	// a change counts only once the second and third stages agree
	genvar gp;
	generate
		for (gp = 0; gp < 16; gp++) begin : g_sync
			always_ff @(posedge i_mclk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					pin_s1_q[gp] <= 1'b1;
					pin_s2_q[gp] <= 1'b1;
					pin_s3_q[gp] <= 1'b1;
					pin_stable_q[gp] <= 1'b1;
				end else begin
					pin_s1_q[gp] <= pin_raw[gp]; // RULE_20
					pin_s2_q[gp] <= pin_s1_q[gp];
					pin_s3_q[gp] <= pin_s2_q[gp];
					if (pin_s2_q[gp] == pin_s3_q[gp]) begin
						pin_stable_q[gp] <= pin_s3_q[gp];
					end
				end
			end
		end
	endgenerate

	// ************************************************************
	// registers
	// ************************************************************

	logic [7:0] sens_q;
	logic [7:0] sel_q;
	logic [3:0] pend_q;
	logic [3:0] line_prev_q;

	// ************************************************************
	// pin selection and enable
	// ************************************************************

	logic [7:0] port_a_stable;
	logic [7:0] port_b_stable;
	logic [7:0] port_a_irq_en;
	logic [7:0] port_b_irq_en;
	logic [1:0] sel3;
	logic [1:0] sel2;
	logic [2:0] line2_pin;
	logic [3:0] line_level;
	logic [3:0] line_en;
	logic [1:0] line_mode [4];
	logic in_halt;
	logic line2_blocked;

	assign port_a_stable = pin_stable_q[7:0];
	assign port_b_stable = pin_stable_q[15:8];
	// a pin interrupts only as input with its option bit set
	assign port_a_irq_en = ~i_port_a_dir & i_port_a_opt; // RULE_19
	assign port_b_irq_en = ~i_port_b_dir & i_port_b_opt; // RULE_19
	assign sel3 = sel_q[`L3_FIELD];
	assign sel2 = sel_q[`L2_FIELD];
	assign line2_pin = `LINE2_BASE + {1'b0, sel2}; // RULE_13

	assign line_level[0] = port_a_stable[`LINE0_PIN]; // RULE_09
	assign line_level[1] = port_a_stable[`LINE1_PIN]; // RULE_09
	assign line_level[2] = port_b_stable[line2_pin]; // RULE_13
	assign line_level[3] = port_b_stable[{1'b0, sel3}]; // RULE_12

	assign in_halt = (i_power_mode == eimap_pkg::PM_HALT) ||
		(i_power_mode == eimap_pkg::PM_AWU_HALT);
	assign line2_blocked = in_halt && (sel2 == `LINE2_PB4); // RULE_15

	assign line_en[0] = port_a_irq_en[`LINE0_PIN];
	assign line_en[1] = port_a_irq_en[`LINE1_PIN];
	assign line_en[2] = port_b_irq_en[line2_pin] & ~line2_blocked;
	// code 11 names no pin for line three, so the line stays idle
	assign line_en[3] = port_b_irq_en[{1'b0, sel3}] &
		(sel3 != `LINE3_NONE); // RULE_12

	assign line_mode[0] = sens_q[`L0_FIELD]; // RULE_08
	assign line_mode[1] = sens_q[`L1_FIELD]; // RULE_08
	assign line_mode[2] = sens_q[`L2_FIELD]; // RULE_08
	assign line_mode[3] = sens_q[`L3_FIELD]; // RULE_08

	// ************************************************************
	// register bus
	// ************************************************************

	logic aw_have_q;
	logic w_have_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [7:0] w_data_q;
	logic w_lane0_q;
	logic wr_fire;
	logic wr_sens;
	logic wr_sel;
	logic sens_ok;
	logic sens_take;
	logic [1:0] wr_resp;
	logic rd_fire;
	logic rd_hit;
	logic [7:0] rd_byte;

	assign wr_fire = aw_have_q & w_have_q & ~o_s_axi_bvalid;
	assign wr_sens = aw_addr_q == ADDR_W'(`SENS_OFS);
	assign wr_sel = aw_addr_q == ADDR_W'(`SEL_OFS);
	// software must mask interrupts first; otherwise the write is refused
	assign sens_ok = i_cc_level == `LEVEL_MASKED; // RULE_11
	assign sens_take = wr_fire & wr_sens & sens_ok & w_lane0_q; // RULE_11
	assign wr_resp = (wr_sel || (wr_sens && sens_ok)) ?
		`RESP_OKAY : `RESP_SLVERR;

	assign rd_fire = i_s_axi_arvalid & o_s_axi_arready;
	assign rd_hit = (i_s_axi_araddr == ADDR_W'(`SENS_OFS)) ||
		(i_s_axi_araddr == ADDR_W'(`SEL_OFS)) ||
		(i_s_axi_araddr == ADDR_W'(`STAT_OFS));
	assign rd_byte = (i_s_axi_araddr == ADDR_W'(`SENS_OFS)) ? sens_q :
		(i_s_axi_araddr == ADDR_W'(`SEL_OFS)) ? sel_q :
		(i_s_axi_araddr == ADDR_W'(`STAT_OFS)) ? {line_level, pend_q} :
		8'h00;

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= 8'h00;
			w_lane0_q <= 1'b0;
			o_s_axi_awready <= 1'b0;
			o_s_axi_wready <= 1'b0;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= `RESP_OKAY;
		end else begin
			o_s_axi_awready <= ~aw_have_q & ~(i_s_axi_awvalid &
				o_s_axi_awready);
			o_s_axi_wready <= ~w_have_q & ~(i_s_axi_wvalid & o_s_axi_wready);
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= i_s_axi_awaddr;
			end
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= i_s_axi_wdata[7:0];
				w_lane0_q <= i_s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_bresp <= wr_resp;
			end else if (o_s_axi_bvalid && i_s_axi_bready) begin
				o_s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h0000_0000;
			o_s_axi_rresp <= `RESP_OKAY;
		end else begin
			o_s_axi_arready <= ~o_s_axi_rvalid & ~rd_fire;
			if (rd_fire) begin
				o_s_axi_rvalid <= 1'b1;
				o_s_axi_rdata <= {24'h00_0000, rd_byte};
				o_s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (o_s_axi_rvalid && i_s_axi_rready) begin
				o_s_axi_rvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sens_q <= `SENS_RST;
			sel_q <= `SEL_RST; // RULE_14
		end else begin
			if (sens_take) begin
				sens_q <= w_data_q; // RULE_11
			end
			if (wr_fire && wr_sel && w_lane0_q) begin
				sel_q <= w_data_q;
			end
		end
	end

	// ************************************************************
	// external line latches
	// ************************************************************

	logic [3:0] line_evt;
	logic [3:0] line_hold;
	logic [3:0] fetch_clr;
	logic [3:0] pend_d;
	logic [3:0] ext_req;
	logic fetch_ext;

	assign fetch_ext = i_vec_fetch & o_irq.valid &
		(o_irq.slot >= `SLOT_EXT0) & (o_irq.slot < `SLOT_EXT0 + 4'h4);

	genvar gl;
	generate
		for (gl = 0; gl < 4; gl++) begin : g_line
			assign line_evt[gl] = line_en[gl] & sense_event(line_mode[gl],
				line_prev_q[gl], line_level[gl]); // RULE_20
			// fall+low keeps asking while the pin is held low
			assign line_hold[gl] = line_en[gl] & ~line_level[gl] &
				(line_mode[gl] == `SENSE_FALL_LOW); // RULE_20
			assign fetch_clr[gl] = fetch_ext &
				(o_irq.slot == `SLOT_EXT0 + 4'(gl)); // RULE_17
			// a new edge in the fetch cycle survives the clear
			assign pend_d[gl] = line_evt[gl] |
				(pend_q[gl] & ~fetch_clr[gl]); // RULE_17
			assign ext_req[gl] = (pend_q[gl] | line_hold[gl]) & line_en[gl];
		end
	endgenerate

	// a sensitivity change wipes pending lines, edges included
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pend_q <= 4'h0;
			line_prev_q <= 4'hF;
		end else begin
			line_prev_q <= line_level; // RULE_20
			if (sens_take) begin
				pend_q <= 4'h0; // RULE_18
			end else begin
				pend_q <= pend_d;
			end
		end
	end

	// ************************************************************
	// priority, wake-up and vector
	// ************************************************************

	logic reset_pend_q;
	logic [15:0] raw_req;
	logic [15:0] wake_mask;
	logic [15:0] eff_req;
	logic [3:0] win_slot;
	logic [15:0] win_vector;

	assign raw_req = {
		1'b0,
		i_periph_req.spi,
		i_periph_req.lite_one, // RULE_03
		i_periph_req.lite_cap, // RULE_04
		i_periph_req.at_ovf, // RULE_02
		i_periph_req.at_cmp,
		i_periph_req.supply_warning_source,
		1'b0,
		i_periph_req.lite_two, // RULE_05
		ext_req,
		i_periph_req.auto_wake_source, // RULE_06
		i_periph_req.trap,
		reset_pend_q
	}; // RULE_01

	// in a low-power mode only sources able to end that mode are seen
	assign wake_mask =
		(i_power_mode == eimap_pkg::PM_HALT) ? `WAKE_HALT : // RULE_07
		(i_power_mode == eimap_pkg::PM_AWU_HALT) ? `WAKE_AWU_HALT : // RULE_06
		(i_power_mode == eimap_pkg::PM_ACTIVE_HALT) ? `WAKE_ACT_HALT :
		`WAKE_RUN; // RULE_02
	assign eff_req = raw_req & wake_mask;
	assign win_slot = first_set(eff_req); // RULE_01
	assign win_vector = `VEC_TOP - {11'h000, win_slot, 1'b0}; // RULE_01

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			reset_pend_q <= 1'b1;
			o_irq <= '0;
			o_wake <= 1'b0;
			o_cc_push <= 1'b0;
			o_cc_level <= `LEVEL_MASKED;
		end else begin
			if (i_vec_fetch && o_irq.valid && o_irq.slot == `SLOT_RESET) begin
				reset_pend_q <= 1'b0;
			end
			o_irq.valid <= |eff_req;
			o_irq.slot <= win_slot;
			o_irq.vector <= win_vector;
			o_wake <= (|eff_req) && (i_power_mode != eimap_pkg::PM_RUN);
			// reset entry saves nothing, so no push for slot zero
			o_cc_push <= i_vec_fetch & o_irq.valid &
				(o_irq.slot != `SLOT_RESET); // RULE_16
			if (i_vec_fetch && o_irq.valid) begin
				o_cc_level <= i_routine_level; // RULE_16
			end
		end
	end

endmodule : ext_interrupt_and_vector_map

// >>> sim/eimap_asserts.sv
// checker for the interrupt map: vectors, mode masks, push, bus holds
// assumes one clock domain and sees only the top module's ports
`timescale 1ns/1ps
module eimap_asserts (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_s_axi_arvalid,
	input wire logic o_s_axi_arready,
	input wire logic o_s_axi_rvalid,
	input wire logic i_s_axi_bready,
	input wire logic o_s_axi_bvalid,
	input wire logic [1:0] o_s_axi_bresp,
	input wire eimap_pkg::power_mode_e i_power_mode,
	input wire logic [1:0] i_routine_level,
	input wire logic i_vec_fetch,
	input wire eimap_pkg::irq_req_s o_irq,
	input wire logic o_wake,
	input wire logic o_cc_push,
	input wire logic [1:0] o_cc_level
);
	// ****
	// properties
	// ****
	localparam logic [15:0] halt_m = 16'h4079;
	localparam logic [15:0] awu_m = 16'h407D;
	localparam logic [15:0] act_m = 16'h2801;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);
	a_vector_map: assert property (
		o_irq.valid |-> o_irq.vector == 16'hFFFE - {11'h0, o_irq.slot, 1'b0})
		else $error("vector does not match slot");
	// o_irq lags one cycle, so the mode must have held across it
	a_halt_mask: assert property (
		$stable(i_power_mode) && i_power_mode == eimap_pkg::PM_HALT
		&& o_irq.valid |-> halt_m[o_irq.slot])
		else $error("halt shows a source that cannot wake it");
	a_active_mask: assert property (
		$stable(i_power_mode) && i_power_mode == eimap_pkg::PM_ACTIVE_HALT
		&& o_irq.valid |-> act_m[o_irq.slot])
		else $error("active halt shows a masked source");
	a_awu_mask: assert property (
		$stable(i_power_mode) && i_power_mode == eimap_pkg::PM_AWU_HALT
		&& o_irq.valid |-> awu_m[o_irq.slot])
		else $error("auto wake halt shows a masked source");
	a_run_no_wake: assert property (
		$stable(i_power_mode) && i_power_mode == eimap_pkg::PM_RUN |-> !o_wake)
		else $error("wake raised in run mode");
	a_push_on_fetch: assert property (
		i_vec_fetch && o_irq.valid && o_irq.slot != 4'h0 |=> o_cc_push)
		else $error("no push after fetch");
	a_push_level: assert property (
		i_vec_fetch && o_irq.valid |=> o_cc_level == $past(i_routine_level))
		else $error("priority level not loaded");
	a_push_cause: assert property (
		o_cc_push |-> $past(i_vec_fetch) && $past(o_irq.slot) != 4'h0)
		else $error("push without fetch");
	a_bresp_hold: assert property (
		o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid
		&& $stable(o_s_axi_bresp))
		else $error("write response dropped");
	a_read_answer: assert property (
		i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
		else $error("read not answered");
	c_fetch: cover property (i_vec_fetch && o_irq.valid);
	c_wake: cover property (o_wake);
	c_slverr: cover property (o_s_axi_bvalid && o_s_axi_bresp == 2'h2);
endmodule : eimap_asserts

bind ext_interrupt_and_vector_map eimap_asserts i_chk (
	.i_mclk, .i_rst_n, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rvalid,
	.i_s_axi_bready, .o_s_axi_bvalid, .o_s_axi_bresp, .i_power_mode,
	.i_routine_level, .i_vec_fetch, .o_irq, .o_wake, .o_cc_push, .o_cc_level
);

// >>> sim/core_model.sv
// core side model: fetches the shown vector after a programmable wait
// assumes it runs on the design clock and watches o_irq directly
`timescale 1ns/1ps
module core_model (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_en,
	input wire logic [3:0] i_delay,
	input wire eimap_pkg::irq_req_s i_irq,
	output logic o_vec_fetch
);
	// ****
	// fetch timing
	// ****
	logic [4:0] wait_q;
	logic fire;
	// three spare cycles let the design retire the fetched slot first
	assign fire = i_en && i_irq.valid && wait_q >= {1'b0, i_delay} + 5'h3;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wait_q <= 5'h0;
			o_vec_fetch <= 1'b0;
		end else begin
			o_vec_fetch <= fire;
			wait_q <= (fire || !i_irq.valid) ? 5'h0 : wait_q + 5'h1;
		end
	end
endmodule : core_model

// >>> sim/tb.sv
// self-checking bench for the external interrupt front end
// assumes core_model.sv and the bound checker are compiled alongside
`timescale 1ns/1ps
`include "eimap_cfg.svh"
module tb;
	// ****
	// signals and design
	// ****
	logic mclk, rst_n, aw_valid, w_valid, b_ready, ar_valid, r_ready;
	logic core_en, aw_ready, w_ready, b_valid, ar_ready, r_valid;
	logic vec_fetch, wake, push;
	logic [7:0] aw_addr, ar_addr, port_a, port_b, dir, opt;
	logic [31:0] w_data, r_data;
	logic [1:0] b_resp, r_resp, cc_level, rout_lvl, cc_out;
	logic [3:0] delay;
	eimap_pkg::periph_req_s preq;
	eimap_pkg::power_mode_e pmode;
	eimap_pkg::irq_req_s irq;
	int pin_of[4] = '{0, 7, 11, 8};
	int seed = 15;
	int n_mismatch = 0;
	int samples_checked = 0;
	always #5 mclk = ~mclk;
	ext_interrupt_and_vector_map i_dut (
		.i_mclk(mclk), .i_rst_n(rst_n),
		.i_s_axi_awvalid(aw_valid), .o_s_axi_awready(aw_ready),
		.i_s_axi_awaddr(aw_addr), .i_s_axi_wvalid(w_valid),
		.o_s_axi_wready(w_ready), .i_s_axi_wdata(w_data),
		.i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(b_valid),
		.i_s_axi_bready(b_ready), .o_s_axi_bresp(b_resp),
		.i_s_axi_arvalid(ar_valid), .o_s_axi_arready(ar_ready),
		.i_s_axi_araddr(ar_addr), .o_s_axi_rvalid(r_valid),
		.i_s_axi_rready(r_ready), .o_s_axi_rdata(r_data),
		.o_s_axi_rresp(r_resp), .i_port_a(port_a), .i_port_b(port_b),
		.i_port_a_dir(dir), .i_port_a_opt(opt), .i_port_b_dir(dir),
		.i_port_b_opt(opt), .i_periph_req(preq), .i_power_mode(pmode),
		.i_cc_level(cc_level), .i_routine_level(rout_lvl),
		.i_vec_fetch(vec_fetch), .o_irq(irq), .o_wake(wake),
		.o_cc_push(push), .o_cc_level(cc_out)
	);
	core_model i_core (
		.i_mclk(mclk), .i_rst_n(rst_n), .i_en(core_en), .i_delay(delay),
		.i_irq(irq), .o_vec_fetch(vec_fetch)
	);
	// ****
	// helpers and reference model
	// ****
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic check_irq(input logic [15:0] req);
		logic [15:0] m;
		int s;
		case (pmode)
			eimap_pkg::PM_HALT: m = `WAKE_HALT & req;
			eimap_pkg::PM_AWU_HALT: m = `WAKE_AWU_HALT & req;
			eimap_pkg::PM_ACTIVE_HALT: m = `WAKE_ACT_HALT & req;
			default: m = req;
		endcase
		s = 0;
		while (s < 15 && !m[s])
			s++;
		if (m == 16'h0)
			check({31'h0, irq.valid}, 32'h0);
		else
			check({11'h0, irq}, {12'h1, 4'(s), 16'hFFFE - 16'(2 * s)});
		check({31'h0, wake}, {31'h0, pmode != eimap_pkg::PM_RUN && m != 0});
	endtask : check_irq
	function automatic logic [15:0] pvec(input eimap_pkg::periph_req_s p);
		return {1'b0, p.spi, p.lite_one, p.lite_cap, p.at_ovf, p.at_cmp,
			p.supply_warning_source, 1'b0, p.lite_two, 4'h0, p.auto_wake_source, p.trap, 1'b0};
	endfunction : pvec
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] er);
		int n;
		aw_addr <= a;
		w_data <= {24'h0, d};
		{aw_valid, w_valid, b_ready} <= 3'h7;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
			if (aw_valid && aw_ready) aw_valid <= 1'b0;
			if (w_valid && w_ready) w_valid <= 1'b0;
		end while (!b_valid && n < 100);
		b_ready <= 1'b0;
		check({30'h0, b_resp}, {30'h0, er});
		if (n >= 100) begin
			n_mismatch++;
			stop_test();
		end
		// an idle edge so a following call never re-raises bready at once
		@(posedge mclk);
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] er);
		int n;
		ar_addr <= a;
		{ar_valid, r_ready} <= 2'h3;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
			if (ar_valid && ar_ready) ar_valid <= 1'b0;
		end while (!r_valid && n < 100);
		r_ready <= 1'b0;
		check(r_data, {24'h0, d});
		check({30'h0, r_resp}, {30'h0, er});
		if (n >= 100) begin
			n_mismatch++;
			stop_test();
		end
		@(posedge mclk);
	endtask : axi_rd
	task automatic set_pin(input int b, input logic v);
		{port_b, port_a} <= {port_b, port_a} & ~(16'h1 << b) | (16'(v) << b);
		repeat (8) @(posedge mclk);
	endtask : set_pin
	// each fetch must be followed by the loaded level, and by the push pulse unless it was slot zero
	logic fetch_q = 1'b0;
	logic slot0_q;
	logic [1:0] lvl_q;
	always @(posedge mclk) begin : fetch_mon
		if (fetch_q) begin
			check({31'h0, push}, {31'h0, !slot0_q});
			check({30'h0, cc_out}, {30'h0, lvl_q});
		end
		fetch_q <= rst_n && vec_fetch && irq.valid;
		slot0_q <= irq.slot == 4'h0;
		lvl_q <= rout_lvl;
	end
	// ****
	// main sequence
	// ****
	initial begin : main
		int l, g;
		logic e;
		{mclk, rst_n, aw_valid, w_valid, b_ready, ar_valid, r_ready} = '0;
		{aw_addr, ar_addr, w_data, dir, cc_level, rout_lvl, delay} = '0;
		{port_a, port_b, opt} = '1;
		core_en = 1'b0;
		preq = '0;
		pmode = eimap_pkg::PM_RUN;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		check_irq(16'h0001);
		axi_rd(`SEL_OFS, 8'h0C, `RESP_OKAY);
		axi_rd(`SENS_OFS, 8'h00, `RESP_OKAY);
		axi_rd(8'h10, 8'h00, `RESP_SLVERR);
		axi_wr(`STAT_OFS, 8'hFF, `RESP_SLVERR);
		core_en <= 1'b1;
		repeat (12) @(posedge mclk);
		check_irq(16'h0000);
		axi_wr(`SENS_OFS, 8'h55, `RESP_SLVERR);
		cc_level <= 2'h3;
		axi_wr(`SENS_OFS, 8'hE4, `RESP_OKAY);
		axi_rd(`SENS_OFS, 8'hE4, `RESP_OKAY);
		$display("test registers done");
		core_en <= 1'b0;
		repeat (16) begin
			pmode <= eimap_pkg::power_mode_e'(2'($random(seed)));
			preq <= 9'($random(seed));
			repeat (3) @(posedge mclk);
			check_irq(pvec(preq));
		end
		preq <= '0;
		pmode <= eimap_pkg::PM_RUN;
		$display("test priority done");
		for (int c = 0; c < 4; c++) begin
			repeat (4) begin
				l = $random(seed) & 3;
				g = $random(seed) & 3;
				e = (g == 1);
				dir <= {8{g[1]}};
				opt <= {8{g[0]}};
				rout_lvl <= 2'($random(seed));
				delay <= 4'($random(seed));
				axi_wr(`SENS_OFS, 8'(c << (2 * l)), `RESP_OKAY);
				set_pin(pin_of[l], 1'b0);
				check_irq(16'(e && c != 1) << (3 + l));
				set_pin(pin_of[l], 1'b1);
				check_irq(16'(e) << (3 + l));
				core_en <= l[0] ^ c[0];
				if (l[0] ^ c[0])
					repeat (25) @(posedge mclk);
				else
					axi_wr(`SENS_OFS, 8'(c << (2 * l)), `RESP_OKAY);
				check_irq(16'h0000);
				core_en <= 1'b0;
			end
		end
		$display("test pins done");
		{dir, opt} <= 16'h00FF;
		axi_wr(`SEL_OFS, 8'h5C, `RESP_OKAY);
		axi_wr(`SENS_OFS, 8'hA0, `RESP_OKAY);
		set_pin(9, 1'b0);
		check_irq(16'h0040);
		set_pin(12, 1'b0);
		check_irq(16'h0060);
		{port_a, port_b} <= '1;
		axi_wr(`SENS_OFS, 8'hA0, `RESP_OKAY);
		pmode <= eimap_pkg::PM_HALT;
		@(posedge mclk);
		set_pin(12, 1'b0);
		check_irq(16'h0000);
		// line three on code 11 must stay idle even when pin b3 falls
		axi_wr(`SEL_OFS, 8'hCC, `RESP_OKAY);
		set_pin(11, 1'b0);
		check_irq(16'h0020);
		axi_rd(`STAT_OFS, 8'h34, `RESP_OKAY);
		$display("test pin select done");
		stop_test();
	end
endmodule : tb
